// *** src/sar_adc_defs.svh ***
// constants for the successive-approximation converter control block
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADC_OFS_CTRL        8'h00
`define ADC_OFS_CONFIG      8'h04
`define ADC_OFS_ANALOG_CFG  8'h08
`define ADC_OFS_STATUS      8'h0C
`define ADC_OFS_RESULT      8'h10
`define ADC_OFS_IRQ_STATUS  8'h14
`define ADC_OFS_IRQ_ENABLE  8'h18
`define ADC_OFS_IRQ_CLEAR   8'h1C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_POWER_BIT      0
`define CTRL_START_BIT      1
`define CFG_DIV_LSB         0
`define CFG_SHW_LSB         2
`define CFG_RES_LSB         4
`define CFG_REFLVL_LSB      6
`define CFG_EXTREF_BIT      8
`define CFG_GATE_BIT        9
`define CFG_CHS_LSB         10
`define CFG_WIDTH           14
`define ANA_PA_LSB          0
`define ANA_PB_LSB          8
`define PA_PINS             5
`define PB_PINS             8
`define STAT_DONE_BIT       0
`define STAT_BUSY_BIT       1
`define IRQ_DONE_BIT        0
`define IRQ_WIDTH           1

// ----------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------
`define CFG_RESET           14'h0000
`define PB_ANALOG_MASK      8'hFE
`define DIV_SEL_16          2'h0
`define DIV_SEL_8           2'h1
`define DIV_SEL_1           2'h2
`define DIV_SEL_2           2'h3
`define SHW_SEL_1           2'h0
`define SHW_SEL_2           2'h1
`define SHW_SEL_4           2'h2
`define SHW_SEL_8           2'h3
`define RES_SEL_8           2'h0
`define RES_SEL_10          2'h1
`define CHS_NONE_PREFIX     3'h7
`define RESULT_BITS         12
`define TRIAL_MSB           12'h800
`define FINISH_TICKS_LAST   4'h1

`endif

// *** src/sar_adc_pkg.sv ***
// types shared by the converter control modules
package sar_adc_pkg;

   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_SAMPLE,
      SEQ_CONVERT,
      SEQ_FINISH
   } seq_state_t;

   typedef struct packed {
      logic [3:0] count;
   } div_regs_t;

   typedef struct packed {
      seq_state_t  state;
      logic [3:0]  count;
      logic [3:0]  sample_last;
      logic [3:0]  lsb;
      logic [3:0]  bit_idx;
      logic [11:0] code;
      logic [11:0] result;
      logic        done;
      logic        sample_hold;
   } seq_regs_t;

   typedef struct packed {
      logic        power;
      logic [13:0] cfg;
      logic [4:0]  pa_analog;
      logic [7:0]  pb_analog;
      logic [0:0]  irq_status;
      logic [0:0]  irq_enable;
      logic        start_pulse;
      logic        done_prev;
      logic        comp_meta;
      logic        comp_sync;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        ref_external;
      logic [1:0]  ref_level;
      logic        mux_connect;
      logic [3:0]  mux_code;
   } ctl_regs_t;

endpackage

// *** src/conv_clock_gen.sv ***
// conversion clock tick generator derived from the CPU clock
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_defs.svh"

module conv_clock_gen #(
   parameter int CNT_WIDTH = 4
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control
   input  wire logic [1:0] div_sel,
   input  wire logic       restart,
   // tick out
   output logic            tick
);

   initial begin
      if (CNT_WIDTH < 4) $error("conv_clock_gen: counter too narrow for divide by 16");
   end

   function automatic logic [3:0] div_last(input logic [1:0] sel);
      unique case (sel)
         `DIV_SEL_16: div_last = 4'hF;
         `DIV_SEL_8:  div_last = 4'h7;
         `DIV_SEL_1:  div_last = 4'h0;
         `DIV_SEL_2:  div_last = 4'h1;
      endcase
   endfunction

   sar_adc_pkg::div_regs_t r;
   sar_adc_pkg::div_regs_t next_r;

   assign tick = (r.count == div_last(div_sel));

   always_comb begin
      next_r = r;
      // restart aligns ticks to the start command
      if (restart || tick) begin
         next_r.count = 4'h0;
      end else begin
         next_r.count = r.count + 4'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule
`default_nettype wire

// *** src/sar_sequencer.sv ***
// successive-approximation sequencer: sample window, bit trials, finish
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_defs.svh"

module sar_sequencer #(
   parameter int RESULT_WIDTH = 12
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // control
   input  wire logic        power,
   input  wire logic        start,
   input  wire logic        tick,
   input  wire logic [1:0]  sample_sel,
   input  wire logic [1:0]  res_sel,
   input  wire logic        comp_high,
   // status
   output logic             accept,
   output logic             busy,
   output logic             done,
   output logic [11:0]      result,
   // analog front end
   output logic             sample_hold,
   output logic [11:0]      dac_code
);

   initial begin
      if (RESULT_WIDTH != `RESULT_BITS) $error("sar_sequencer: only 12-bit result supported");
   end

   function automatic logic [3:0] sample_last(input logic [1:0] sel);
      unique case (sel)
         `SHW_SEL_1: sample_last = 4'h0;
         `SHW_SEL_2: sample_last = 4'h1;
         `SHW_SEL_4: sample_last = 4'h3;
         `SHW_SEL_8: sample_last = 4'h7;
      endcase
   endfunction

   function automatic logic [3:0] res_lsb(input logic [1:0] sel);
      if (sel == `RES_SEL_8) begin
         res_lsb = 4'h4;
      end else if (sel == `RES_SEL_10) begin
         res_lsb = 4'h2;
      end else begin
         res_lsb = 4'h0;
      end
   endfunction

   sar_adc_pkg::seq_regs_t r;
   sar_adc_pkg::seq_regs_t next_r;

   assign accept      = start && power && (r.state == sar_adc_pkg::SEQ_IDLE);
   assign busy        = (r.state != sar_adc_pkg::SEQ_IDLE);
   assign done        = r.done;
   assign result      = r.result;
   assign sample_hold = r.sample_hold;
   assign dac_code    = r.code;

   always_comb begin
      next_r = r;
      if (!power) begin
         next_r.state       = sar_adc_pkg::SEQ_IDLE;
         next_r.sample_hold = 1'b0;
      end else begin
         unique case (r.state)
            sar_adc_pkg::SEQ_IDLE: begin
               if (accept) begin
                  next_r.state       = sar_adc_pkg::SEQ_SAMPLE;
                  next_r.count       = 4'h0;
                  next_r.sample_last = sample_last(sample_sel);
                  next_r.lsb         = res_lsb(res_sel);
                  next_r.bit_idx     = 4'hB;
                  next_r.code        = `TRIAL_MSB;
                  next_r.done        = 1'b0;
                  next_r.sample_hold = 1'b1;
               end
            end
            sar_adc_pkg::SEQ_SAMPLE: begin
               if (tick) begin
                  next_r.count = r.count + 4'h1;
                  if (r.count == r.sample_last) begin
                     next_r.state       = sar_adc_pkg::SEQ_CONVERT;
                     next_r.sample_hold = 1'b0;
                  end
               end
            end
            sar_adc_pkg::SEQ_CONVERT: begin
               if (tick) begin
                  if (!comp_high) begin
                     next_r.code[r.bit_idx] = 1'b0;
                  end
                  if (r.bit_idx == r.lsb) begin
                     next_r.state = sar_adc_pkg::SEQ_FINISH;
                     next_r.count = 4'h0;
                  end else begin
                     next_r.bit_idx              = r.bit_idx - 4'h1;
                     next_r.code[r.bit_idx - 4'h1] = 1'b1;
                  end
               end
            end
            sar_adc_pkg::SEQ_FINISH: begin
               if (tick) begin
                  next_r.count = r.count + 4'h1;
                  if (r.count == `FINISH_TICKS_LAST) begin
                     next_r.state  = sar_adc_pkg::SEQ_IDLE;
                     next_r.result = r.code >> r.lsb;
                     next_r.done   = 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

endmodule
`default_nettype wire

// *** src/sar_adc_control.sv ***
// converter control top: APB registers, interrupt, analog routing
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_defs.svh"

module sar_adc_control (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // cpu interrupt
   input  wire logic        global_irq_enable,
   output logic             irq,
   // analog front end
   input  wire logic        comp_high,
   output logic             sample_hold,
   output logic [11:0]      dac_code,
   output logic             ref_external,
   output logic [1:0]       ref_level,
   output logic             mux_connect,
   output logic [3:0]       mux_code,
   // pin configuration
   output logic [4:0]       port_a_analog_cfg,
   output logic [7:0]       port_b_analog_cfg
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sar_adc_pkg::ctl_regs_t r;
   sar_adc_pkg::ctl_regs_t next_r;

   logic        tick;
   logic        accept;
   logic        busy;
   logic        done;
   logic [11:0] result;
   logic [11:0] seq_dac;
   logic        seq_sample;

   logic        wr_en;
   logic        setup;
   logic        done_rise;

   // ----------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------
   conv_clock_gen #(
      .CNT_WIDTH (4)
   ) u_div (
      .clk     (clk),
      .rst_n   (rst_n),
      .div_sel (r.cfg[`CFG_DIV_LSB +: 2]),
      .restart (accept),
      .tick    (tick)
   );

   sar_sequencer #(
      .RESULT_WIDTH (`RESULT_BITS)
   ) u_seq (
      .clk         (clk),
      .rst_n       (rst_n),
      .power       (r.power),
      .start       (r.start_pulse),
      .tick        (tick),
      .sample_sel  (r.cfg[`CFG_SHW_LSB +: 2]),
      .res_sel     (r.cfg[`CFG_RES_LSB +: 2]),
      .comp_high   (r.comp_sync),
      .accept      (accept),
      .busy        (busy),
      .done        (done),
      .result      (result),
      .sample_hold (seq_sample),
      .dac_code    (seq_dac)
   );

   // ----------------------------------------------------------------
   // register read decode
   // ----------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [7:0] addr,
                                              input sar_adc_pkg::ctl_regs_t s,
                                              input logic st_done,
                                              input logic st_busy,
                                              input logic [11:0] st_result);
      read_word = 32'h0000_0000;
      unique case (addr)
         `ADC_OFS_CTRL:       read_word[`CTRL_POWER_BIT] = s.power;
         `ADC_OFS_CONFIG:     read_word[`CFG_WIDTH-1:0] = s.cfg;
         `ADC_OFS_ANALOG_CFG: begin
            read_word[`ANA_PA_LSB +: `PA_PINS] = s.pa_analog;
            read_word[`ANA_PB_LSB +: `PB_PINS] = s.pb_analog;
         end
         `ADC_OFS_STATUS: begin
            read_word[`STAT_DONE_BIT] = st_done;
            read_word[`STAT_BUSY_BIT] = st_busy;
         end
         `ADC_OFS_RESULT:     read_word[`RESULT_BITS-1:0] = st_result;
         `ADC_OFS_IRQ_STATUS: read_word[`IRQ_WIDTH-1:0] = s.irq_status;
         `ADC_OFS_IRQ_ENABLE: read_word[`IRQ_WIDTH-1:0] = s.irq_enable;
         default:             read_word = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic addr_mapped(input logic [7:0] addr);
      unique case (addr)
         `ADC_OFS_CTRL, `ADC_OFS_CONFIG, `ADC_OFS_ANALOG_CFG, `ADC_OFS_STATUS,
         `ADC_OFS_RESULT, `ADC_OFS_IRQ_STATUS, `ADC_OFS_IRQ_ENABLE,
         `ADC_OFS_IRQ_CLEAR: addr_mapped = 1'b1;
         default:            addr_mapped = 1'b0;
      endcase
   endfunction

   // writes land at the access edge, when pready is already high
   assign setup     = psel && !penable;
   assign wr_en     = psel && penable && pready && pwrite && addr_mapped(paddr);
   assign done_rise = done && !r.done_prev;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_r = r;

      // comparator is asynchronous to clk; first flop feeds only the second
      next_r.comp_meta   = comp_high;
      next_r.comp_sync   = r.comp_meta;
      next_r.done_prev   = done;
      next_r.start_pulse = 1'b0;

      // no wait state: answer is prepared in setup, presented in the first access cycle
      next_r.pready  = setup;
      next_r.pslverr = setup && !addr_mapped(paddr);
      next_r.prdata  = setup && !pwrite ? read_word(paddr, r, done, busy, result) : 32'h0000_0000;

      if (wr_en) begin
         unique case (paddr)
            `ADC_OFS_CTRL: begin
               next_r.power       = pwdata[`CTRL_POWER_BIT];
               next_r.start_pulse = pwdata[`CTRL_START_BIT];
            end
            `ADC_OFS_CONFIG:     next_r.cfg = pwdata[`CFG_WIDTH-1:0];
            `ADC_OFS_ANALOG_CFG: begin
               next_r.pa_analog = pwdata[`ANA_PA_LSB +: `PA_PINS];
               // port B pin 0 has no analog path
               next_r.pb_analog = pwdata[`ANA_PB_LSB +: `PB_PINS] & `PB_ANALOG_MASK;
            end
            `ADC_OFS_IRQ_ENABLE: next_r.irq_enable = pwdata[`IRQ_WIDTH-1:0];
            `ADC_OFS_IRQ_CLEAR:  next_r.irq_status = r.irq_status & ~pwdata[`IRQ_WIDTH-1:0];
            default:             next_r.irq_enable = r.irq_enable;
         endcase
      end

      // done edge sets sticky flag; set beats a same-cycle clear
      if (done_rise) begin
         next_r.irq_status[`IRQ_DONE_BIT] = 1'b1;
      end
      next_r.irq = |(next_r.irq_status & next_r.irq_enable) && global_irq_enable;

      // external reference overrides the level field
      next_r.ref_external = r.cfg[`CFG_EXTREF_BIT];
      // internal level passed only when external is off
      next_r.ref_level    = r.cfg[`CFG_EXTREF_BIT] ? 2'h0 : r.cfg[`CFG_REFLVL_LSB +: 2];

      // codes 111x leave the mux open
      next_r.mux_connect = r.cfg[`CFG_GATE_BIT] &&
                           (r.cfg[`CFG_CHS_LSB + 1 +: 3] != `CHS_NONE_PREFIX);
      next_r.mux_code    = next_r.mux_connect ? r.cfg[`CFG_CHS_LSB +: 4] : 4'h0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata       = r.prdata;
   assign pready       = r.pready;
   assign pslverr      = r.pslverr;
   assign irq          = r.irq;
   assign sample_hold  = seq_sample;
   assign dac_code     = seq_dac;
   assign ref_external = r.ref_external;
   assign ref_level    = r.ref_level;
   assign mux_connect  = r.mux_connect;
   assign mux_code     = r.mux_code;
   assign port_a_analog_cfg = r.pa_analog;
   assign port_b_analog_cfg = r.pb_analog;

endmodule
`default_nettype wire

// *** verif/analog_front_model.sv ***
// analog model of the pins and internal sources behind the channel mux
`timescale 1ns/100ps
`default_nettype none
module analog_front_model (
   // clock
   input  wire logic        clk,
   // converter side
   input  wire logic        sample_hold,
   input  wire logic [11:0] dac_code,
   input  wire logic        mux_connect,
   input  wire logic [3:0]  mux_code,
   input  wire logic [4:0]  port_a_analog_cfg,
   input  wire logic [7:0]  port_b_analog_cfg,
   // comparator
   output logic             comp_high
);
   logic [11:0] level;
   logic [11:0] held = 12'h000;
   logic        live;
   logic        junk = 1'b0;
   // only a gated source or an analog pin carries a level
   always_comb begin
      if (mux_code < 4'h5)
         live = mux_connect & port_a_analog_cfg[mux_code[2:0]];
      else if (mux_code < 4'hC)
         live = mux_connect & port_b_analog_cfg[3'(mux_code - 4'h4)];
      else
         live = mux_connect;
      level = (mux_code == 4'hC) ? 12'h400 : (mux_code == 4'hD) ? 12'h000 : {mux_code, 8'h5C};
   end
   // floating input toggles, so a stale level never passes by luck
   always @(posedge clk) begin
      junk <= ~junk;
      if (sample_hold)
         held <= level;
   end
   // half a step above the held code keeps every trial decision clear
   assign comp_high = live ? ({held, 1'b1} > {dac_code, 1'b0}) : junk;
endmodule
`default_nettype wire

// *** verif/sar_adc_checker.sv ***
// port-level assertions for the converter control block
`timescale 1ns/100ps
`default_nettype none
module sar_adc_checker (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   // interrupt
   input  wire logic        global_irq_enable,
   input  wire logic        irq,
   // analog side
   input  wire logic        sample_hold,
   input  wire logic [11:0] dac_code,
   input  wire logic        ref_external,
   input  wire logic [1:0]  ref_level,
   input  wire logic        mux_connect,
   input  wire logic [3:0]  mux_code,
   input  wire logic [7:0]  port_b_analog_cfg
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   apb_answer_a: assert property (psel && !penable |=> pready && psel && penable)
      else $error("no answer after setup");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   unmapped_err_a: assert property (pready && paddr > 8'h1F |-> pslverr)
      else $error("unmapped access without error");
   read_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   irq_gate_a: assert property (irq |-> $past(global_irq_enable))
      else $error("interrupt without global enable");
   ext_ref_a: assert property (ref_external |-> ref_level == 2'h0)
      else $error("level drives with external ref");
   gate_off_a: assert property (!mux_connect |-> mux_code == 4'h0)
      else $error("channel routed while gated off");
   no_source_a: assert property (mux_connect |-> mux_code[3:1] != 3'h7)
      else $error("empty code connected");
   pin_zero_a: assert property (port_b_analog_cfg[0] == 1'b0)
      else $error("port b pin zero set analog");
   window_open_a: assert property ($rose(sample_hold) |-> dac_code == 12'h800)
      else $error("trial code wrong at sampling");
   window_still_a: assert property (sample_hold && $past(sample_hold) |-> $stable(dac_code))
      else $error("trial code moved while sampling");

   cover property ($rose(irq));
   cover property (pslverr);
   cover property ($fell(sample_hold));
endmodule
bind sar_adc_control sar_adc_checker watch (.clk, .rst_n, .psel, .penable, .paddr, .prdata,
   .pready, .pslverr, .global_irq_enable, .irq, .sample_hold, .dac_code, .ref_external,
   .ref_level, .mux_connect, .mux_code, .port_b_analog_cfg);
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
`include "sar_adc_defs.svh"
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        global_irq_enable = 1'b1;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, comp_high, sample_hold, ref_external, mux_connect;
   logic [11:0] dac_code;
   logic [1:0]  ref_level;
   logic [3:0]  mux_code;
   logic [4:0]  port_a_analog_cfg;
   logic [7:0]  port_b_analog_cfg;
   int          miscompares = 0;
   int          cmp_count = 0;

   always #50 clk = ~clk;

   sar_adc_control dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .global_irq_enable, .irq, .comp_high, .sample_hold, .dac_code,
      .ref_external, .ref_level, .mux_connect, .mux_code, .port_a_analog_cfg,
      .port_b_analog_cfg);
   analog_front_model afe (.clk, .sample_hold, .dac_code, .mux_connect, .mux_code,
      .port_a_analog_cfg, .port_b_analog_cfg, .comp_high);

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         miscompares++;
         results();
      end
      q = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp, what);
   endtask

   // window plus bits plus two divided clocks, times the divider, in CPU clocks
   function automatic int conv_ticks(input logic [1:0] dv, sw, rs);
      int d;
      d = (dv == 2'h0) ? 16 : (dv == 2'h1) ? 8 : (dv == 2'h2) ? 1 : 2;
      return ((1 << sw) + (rs[1] ? 12 : rs[0] ? 10 : 8) + 2) * d;
   endfunction

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      logic [31:0] q;
      logic        e;
      for (int i = 0; i < 8; i++)
         rd(8'(i * 4), 32'h0, "reset value");
      apb(1'b1, 8'h20, 32'hFFFF_FFFF, q, e);
      chk({31'h0, e}, 32'h1, "unmapped error");
      apb(1'b0, 8'h20, 32'h0, q, e);
      chk(q, 32'h0, "unmapped data");
      wr(`ADC_OFS_STATUS, 32'h3);
      rd(`ADC_OFS_STATUS, 32'h0, "status read only");
   endtask

   task automatic t_route();
      wr(`ADC_OFS_CONFIG, 32'h1C0);
      repeat (3) @(posedge clk);
      chk(32'({ref_external, ref_level}), 32'h4, "external ref");
      for (int l = 0; l < 4; l++) begin
         wr(`ADC_OFS_CONFIG, 32'(l << 6));
         repeat (3) @(posedge clk);
         chk(32'({ref_external, ref_level}), 32'(l), "internal ref");
      end
      // gate in bit 0 of c, channel code in the upper bits
      for (int c = 0; c < 32; c++) begin
         wr(`ADC_OFS_CONFIG, 32'(c << 9));
         repeat (3) @(posedge clk);
         chk(32'({mux_connect, mux_code}), (c[0] && c < 28) ? 32'(16 + c / 2) : 32'h0, "route");
      end
      rd(`ADC_OFS_CONFIG, 32'h3E00, "config readback");
   endtask

   task automatic t_pins();
      wr(`ADC_OFS_ANALOG_CFG, 32'hFFFF_FFFF);
      repeat (3) @(posedge clk);
      chk(32'({port_b_analog_cfg, 3'h0, port_a_analog_cfg}), 32'hFE1F, "analog pins");
      rd(`ADC_OFS_ANALOG_CFG, 32'hFE1F, "pins readback");
   endtask

   task automatic one_conv(input logic [1:0] dv, sw, rs, input logic [3:0] ch,
                           input logic [31:0] res, input logic poke);
      time t0;
      int  n;
      n = 0;
      wr(`ADC_OFS_CONFIG, 32'({ch, 1'b1, 3'h0, rs, sw, dv}));
      wr(`ADC_OFS_CTRL, 32'h1);
      wr(`ADC_OFS_CTRL, 32'h3);
      t0 = $time;
      if (poke) begin
         rd(`ADC_OFS_STATUS, 32'h2, "busy while converting");
         wr(`ADC_OFS_CTRL, 32'h3);
      end
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2000) begin
         miscompares++;
         results();
      end
      // start lands, accepted one clock later; irq registers with the sticky event
      chk(32'(($time - t0) / 100), 32'(conv_ticks(dv, sw, rs) + 2), "conversion time");
      rd(`ADC_OFS_STATUS, 32'h1, "done after conversion");
      rd(`ADC_OFS_CTRL, 32'h1, "start reads zero");
      if (dv < 2'h2)
         rd(`ADC_OFS_RESULT, res, "result");
      rd(`ADC_OFS_IRQ_STATUS, 32'h1, "done event");
      wr(`ADC_OFS_IRQ_CLEAR, 32'h1);
      rd(`ADC_OFS_IRQ_STATUS, 32'h0, "event cleared");
      chk({31'h0, irq}, 32'h0, "irq after clear");
   endtask

   task automatic t_irq_mask();
      wr(`ADC_OFS_IRQ_ENABLE, 32'h0);
      wr(`ADC_OFS_CONFIG, 32'h0202);
      wr(`ADC_OFS_CTRL, 32'h3);
      // eleven clocks at divide by one, so twenty is ample
      repeat (20) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "masked irq");
      rd(`ADC_OFS_IRQ_STATUS, 32'h1, "sticky event");
      wr(`ADC_OFS_IRQ_ENABLE, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1, "enabled irq");
      global_irq_enable <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0, "global mask");
      global_irq_enable <= 1'b1;
      wr(`ADC_OFS_IRQ_CLEAR, 32'h1);
      wr(`ADC_OFS_CTRL, 32'h0);
      wr(`ADC_OFS_CTRL, 32'h2);
      repeat (20) @(posedge clk);
      rd(`ADC_OFS_STATUS, 32'h1, "start without power");
      rd(`ADC_OFS_IRQ_STATUS, 32'h0, "no event unpowered");
   endtask

   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_route();
      t_pins();
      wr(`ADC_OFS_IRQ_ENABLE, 32'h1);
      one_conv(2'h2, 2'h0, 2'h0, 4'h0, 32'h0, 1'b0);
      one_conv(2'h3, 2'h1, 2'h1, 4'h5, 32'h0, 1'b0);
      one_conv(2'h1, 2'h2, 2'h2, 4'h6, 32'h65C, 1'b0);
      one_conv(2'h0, 2'h3, 2'h3, 4'hC, 32'h400, 1'b1);
      one_conv(2'h0, 2'h0, 2'h1, 4'h3, 32'hD7, 1'b0);
      t_irq_mask();
      results();
   end
endmodule
`default_nettype wire
